// file: inc/tio_pkg.sv
// Constants for the channel 3 B/D capture/compare I/O control block.
// Assumes a single 40 MHz clock and a plain strobe register port.
//
// What this block does
// - Field 0000/0100 disables the pin; 0001 starts low and 0101 starts high, both drive low on a match.
// - Field 0010 starts low and 0110 starts high, both drive the pin high on a compare match.
// - Field 0011 starts low and 0111 starts high, both invert the pin on every compare match.
// - Field 1000 captures the counter on a rising edge of the pin.
// - Field 1001 captures the counter on a falling edge of the pin.
// - Fields 1010 and 1011 capture on both edges of the pin.
// - Fields 11xx capture whenever the channel 4 counter counts up or down.
// - With channel 4 prescale select 000 the cascaded capture makes no capture.
// - While buffer operation for B/D is set the D field is invalid: no capture, no compare output.
package tio_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [3:0] TIO_IDX_CTRL_HIGH = 4'h0;
  localparam logic [3:0] TIO_IDX_CTRL_LOW = 4'h1;
  localparam logic [3:0] TIO_IDX_GREG_B = 4'h2;
  localparam logic [3:0] TIO_IDX_GREG_D = 4'h3;
  localparam logic [3:0] TIO_IDX_STATUS = 4'h4;
  localparam logic [3:0] TIO_IDX_MASK = 4'h5;
  localparam logic [3:0] TIO_IDX_MODE = 4'h6;

  // ----------------------------------------------------------------
  // Field positions and widths
  // ----------------------------------------------------------------
  localparam int TIO_FIELD_LSB = 4;
  localparam int TIO_CNT_W = 16;
  localparam int TIO_STAT_B = 0;
  localparam int TIO_STAT_D = 1;
  localparam int TIO_MODE_BFB = 0;

  // ----------------------------------------------------------------
  // Reset values and special codes
  // ----------------------------------------------------------------
  localparam logic [7:0] TIO_CTRL_RST = 8'h00;
  localparam logic [15:0] TIO_GREG_RST = 16'hffff;
  localparam logic [2:0] TIO_PSC_UNDIVIDED = 3'h0;

endpackage : tio_pkg

// file: core/tio_chan.sv
// One general register with its pin: compare output or input capture.
// Assumes counter, match and channel 4 count strobe are synchronous.
`timescale 1ns/10ps
module tio_chan (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  input wire logic [3:0] field,
  input wire logic field_wr,
  input wire logic invalid,
  input wire logic cascade_ok,
  // Timer state
  input wire logic [15:0] count,
  input wire logic [15:0] greg,
  input wire logic ch4_count_tick,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // Results
  output logic capture,
  output logic match,
  output logic [15:0] cap_value
);

  logic pin_prev_q;
  logic rise;
  logic fall;
  logic out_mode;

  // Edge detect on the sampled pin
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_prev_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_in;
    end
  end

  assign rise = pin_in & ~pin_prev_q;
  assign fall = ~pin_in & pin_prev_q;
  assign out_mode = ~field[3] & ~invalid;

  // Capture source selection
  always_comb begin
    capture = 1'b0;
    if (field[3] && !invalid) begin
      if (field[2]) begin
        capture = ch4_count_tick & cascade_ok;
      end else if (field[1]) begin
        capture = rise | fall;
      end else if (field[0]) begin
        capture = fall;
      end else begin
        capture = rise;
      end
    end
  end

  assign match = out_mode && (field[1:0] != 2'b00) && (count == greg);
  assign cap_value = count;

  // Pin level: initial on field write, action on match
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= 1'b0;
      pin_oe <= 1'b0;
    end else begin
      pin_oe <= out_mode && (field[1:0] != 2'b00);
      if (field_wr) begin
        pin_out <= field[2];
      end else if (match) begin
        unique case (field[1:0])
          2'b01: pin_out <= 1'b0;
          2'b10: pin_out <= 1'b1;
          2'b11: pin_out <= ~pin_out;
          2'b00: pin_out <= pin_out;
        endcase
      end
    end
  end

endmodule : tio_chan

// file: core/tio_top.sv
// Channel 3 B/D I/O control: registers, two channels, interrupt.
// Assumes inputs synchronous to clock; read data one cycle after strobe.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/10ps
module tio_top (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [15:0] rdata,
  // Timer inputs
  input wire logic [15:0] ch3_count,
  input wire logic ch4_count_tick,
  input wire logic [2:0] ch4_prescale_select,
  // Pins
  input wire logic ch3_pin_b_in,
  output logic ch3_pin_b_out,
  output logic ch3_pin_b_oe,
  input wire logic ch3_pin_d_in,
  output logic ch3_pin_d_out,
  output logic ch3_pin_d_oe,
  // Interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] ctrl_high_q;
  logic [7:0] ctrl_low_q;
  logic [15:0] greg_b_q;
  logic [15:0] greg_d_q;
  logic [1:0] status_q;
  logic [1:0] mask_q;
  logic mode_bfb_q;
  logic [15:0] rdata_q;
  logic irq_q;
  logic wr_high_q;
  logic wr_low_q;
  logic [1:0] status_d;
  logic [1:0] mask_d;

  logic wr_high;
  logic wr_low;
  logic cap_b, cap_d, match_b, match_d;
  logic [15:0] val_b, val_d;
  logic cascade_ok;
  logic [1:0] events;

  assign wr_high = wr_stb && (addr == tio_pkg::TIO_IDX_CTRL_HIGH);
  assign wr_low = wr_stb && (addr == tio_pkg::TIO_IDX_CTRL_LOW);
  assign cascade_ok = (ch4_prescale_select != tio_pkg::TIO_PSC_UNDIVIDED);

  // Control registers
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_high_q <= tio_pkg::TIO_CTRL_RST;
      ctrl_low_q <= tio_pkg::TIO_CTRL_RST;
      mask_q <= 2'h0;
      mode_bfb_q <= 1'b0;
    end else if (wr_stb) begin
      if (wr_high) ctrl_high_q <= wdata[7:0];
      if (wr_low) ctrl_low_q <= wdata[7:0];
      if (addr == tio_pkg::TIO_IDX_MASK) mask_q <= wdata[1:0];
      if (addr == tio_pkg::TIO_IDX_MODE) mode_bfb_q <= wdata[tio_pkg::TIO_MODE_BFB];
    end
  end

  // Field write strobes, delayed until the new field is in place
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wr_high_q <= 1'b0;
      wr_low_q <= 1'b0;
    end else begin
      wr_high_q <= wr_high;
      wr_low_q <= wr_low;
    end
  end

  // ----------------------------------------------------------------
  // Channels
  // ----------------------------------------------------------------
  tio_chan u_chan_b (
    .clock(clock),
    .reset_n(reset_n),
    .field(ctrl_high_q[tio_pkg::TIO_FIELD_LSB +: 4]),
    .field_wr(wr_high_q),
    .invalid(1'b0),
    .cascade_ok(cascade_ok),
    .count(ch3_count),
    .greg(greg_b_q),
    .ch4_count_tick(ch4_count_tick),
    .pin_in(ch3_pin_b_in),
    .pin_out(ch3_pin_b_out),
    .pin_oe(ch3_pin_b_oe),
    .capture(cap_b),
    .match(match_b),
    .cap_value(val_b)
  );

  tio_chan u_chan_d (
    .clock(clock),
    .reset_n(reset_n),
    .field(ctrl_low_q[tio_pkg::TIO_FIELD_LSB +: 4]),
    .field_wr(wr_low_q),
    .invalid(mode_bfb_q),
    .cascade_ok(cascade_ok),
    .count(ch3_count),
    .greg(greg_d_q),
    .ch4_count_tick(ch4_count_tick),
    .pin_in(ch3_pin_d_in),
    .pin_out(ch3_pin_d_out),
    .pin_oe(ch3_pin_d_oe),
    .capture(cap_d),
    .match(match_d),
    .cap_value(val_d)
  );

  // General registers: capture wins over software write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      greg_b_q <= tio_pkg::TIO_GREG_RST;
      greg_d_q <= tio_pkg::TIO_GREG_RST;
    end else begin
      if (cap_b) greg_b_q <= val_b;
      else if (wr_stb && addr == tio_pkg::TIO_IDX_GREG_B) greg_b_q <= wdata;
      if (cap_d) greg_d_q <= val_d;
      else if (wr_stb && addr == tio_pkg::TIO_IDX_GREG_D) greg_d_q <= wdata;
    end
  end

  // Sticky status, write one to clear, set wins
  assign events = {cap_d | match_d, cap_b | match_b};
  always_comb begin
    status_d = status_q | events;
    if (wr_stb && addr == tio_pkg::TIO_IDX_STATUS) begin
      status_d = (status_q & ~wdata[1:0]) | events;
    end
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_q <= 2'h0;
    end else begin
      status_q <= status_d;
    end
  end

  // Interrupt level, aligned with the status and mask being written
  assign mask_d = (wr_stb && addr == tio_pkg::TIO_IDX_MASK) ? wdata[1:0] : mask_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end
  assign irq = irq_q;

  // Read data, one cycle after strobe
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 16'h0000;
    end else if (rd_stb) begin
      unique case (addr)
        tio_pkg::TIO_IDX_CTRL_HIGH: rdata_q <= {8'h00, ctrl_high_q};
        tio_pkg::TIO_IDX_CTRL_LOW: rdata_q <= {8'h00, ctrl_low_q};
        tio_pkg::TIO_IDX_GREG_B: rdata_q <= greg_b_q;
        tio_pkg::TIO_IDX_GREG_D: rdata_q <= greg_d_q;
        tio_pkg::TIO_IDX_STATUS: rdata_q <= {14'h0000, status_q};
        tio_pkg::TIO_IDX_MASK: rdata_q <= {14'h0000, mask_q};
        tio_pkg::TIO_IDX_MODE: rdata_q <= {15'h0000, mode_bfb_q};
        default: rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign rdata = rdata_q;

endmodule : tio_top

// file: dv/tio_pins.sv
// Pin wires of channel 3 B/D.
// Assumes the bench sets the outside levels.
`timescale 1ns/10ps
module tio_pins (
  // Outside levels
  input wire logic b_ext,
  input wire logic d_ext,
  // Device drive
  input wire logic b_out,
  input wire logic b_oe,
  input wire logic d_out,
  input wire logic d_oe,
  // Levels seen by the device
  output logic b_in,
  output logic d_in
);
  // Device level while driven, outside level otherwise
  assign b_in = b_oe ? b_out : b_ext;
  assign d_in = d_oe ? d_out : d_ext;
endmodule : tio_pins

// file: dv/tio_props.sv
// Port checks for the channel 3 B/D control.
// Assumes bind into tio_top; tracks fields from writes.
`timescale 1ns/10ps
module tio_props (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register port
  input wire logic wr_stb,
  input wire logic rd_stb,
  input wire logic [3:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  // Counter
  input wire logic [15:0] ch3_count,
  // Pins and interrupt
  input wire logic ch3_pin_b_out,
  input wire logic ch3_pin_b_oe,
  input wire logic ch3_pin_d_out,
  input wire logic ch3_pin_d_oe,
  input wire logic irq
);
  logic [3:0] fb_q, fd_q;
  logic [15:0] gb_q;
  logic bf_q, ob, od;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Shadow of fields, B register and buffer bit
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fb_q <= 4'h0;
      fd_q <= 4'h0;
      gb_q <= 16'hffff;
      bf_q <= 1'b0;
    end else if (wr_stb) begin
      case (addr)
        4'h0: fb_q <= wdata[7:4];
        4'h1: fd_q <= wdata[7:4];
        4'h2: gb_q <= wdata;
        4'h6: bf_q <= wdata[0];
        default: ;
      endcase
    end
  end
  // Compare output enabled
  assign ob = !fb_q[3] && fb_q[1:0] != 2'h0;
  assign od = !fd_q[3] && fd_q[1:0] != 2'h0;
  a_rdata_idle: assert property (!$past(rd_stb) |-> rdata == 16'h0) else $error("rdata not zero");
  a_b_oe_follow: assert property (ch3_pin_b_oe == $past(ob)) else $error("b enable wrong");
  a_d_oe_follow: assert property (!bf_q && !$past(bf_q) |-> ch3_pin_d_oe == $past(od)) else $error("d enable wrong");
  a_b_init_level: assert property (wr_stb && addr == 4'h0 |=> ##1 ch3_pin_b_out == $past(wdata[6], 2))
    else $error("b initial level wrong");
  a_match_b_action: assert property (ob && ch3_count == gb_q && !wr_stb && !$past(wr_stb) |=>
    ch3_pin_b_out == (fb_q[1:0] == 2'h1 ? 1'b0 : fb_q[1:0] == 2'h2 ? 1'b1 : !$past(ch3_pin_b_out)))
    else $error("b match action");
  a_b_out_cause: assert property ($changed(ch3_pin_b_out) |->
    $past(wr_stb, 2) || $past(ch3_count) == $past(gb_q)) else $error("b pin moved alone");
  a_d_buf_hold: assert property (bf_q && $past(bf_q) && !$past(wr_stb) && !$past(wr_stb, 2) |->
    $stable(ch3_pin_d_out)) else $error("d pin moved in buffer mode");
  a_irq_fall_cause: assert property ($fell(irq) |-> $past(wr_stb)) else $error("irq fell alone");
  c_match: cover property (ob && ch3_count == gb_q);
  c_irq: cover property ($rose(irq));
  c_buffer: cover property (bf_q && fd_q[3]);
endmodule : tio_props
bind tio_top tio_props u_props (.*);

// file: dv/tb_top.sv
// Random and corner tests of channel 3 B/D control.
// Assumes tio_top, tio_pins and the bound checker.
`timescale 1ns/10ps
module tb_top;
  logic clock = 0, reset_n = 0, wr_stb = 0, rd_stb = 0, tick = 0, b_ext = 0, d_ext = 0;
  logic b_in, d_in, b_out, b_oe, d_out, d_oe, irq;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0, cnt = 16'h0, rdata, r = 16'h1, w;
  logic [2:0] psc = 3'h1;
  logic [3:0] fs [7] = '{4'h8, 4'h8, 4'h9, 4'h9, 4'ha, 4'hb, 4'h8};
  int errors = 0, total_checks = 0;
  // Clock
  always #12.5 clock = ~clock;
  tio_top uut (.clock(clock), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .ch3_count(cnt), .ch4_count_tick(tick), .ch4_prescale_select(psc), .ch3_pin_b_in(b_in),
    .ch3_pin_b_out(b_out), .ch3_pin_b_oe(b_oe), .ch3_pin_d_in(d_in), .ch3_pin_d_out(d_out),
    .ch3_pin_d_oe(d_oe), .irq(irq));
  tio_pins pins (.b_ext(b_ext), .d_ext(d_ext), .b_out(b_out), .b_oe(b_oe), .d_out(d_out), .d_oe(d_oe),
    .b_in(b_in), .d_in(d_in));
  // Expectation helpers
  function logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  function logic mexp(logic [3:0] f);
    return f[1:0] == 2'h0 ? f[2] : f[1:0] == 2'h1 ? 1'b0 : f[1:0] == 2'h2 ? 1'b1 : !f[2];
  endfunction : mexp
  function logic cexp(logic [3:0] f, logic s, logic bf);
    return !bf && (f[1] || f[0] == s);
  endfunction : cexp
  // Compare, bus cycles, verdict
  task ck(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : ck
  task wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock) {addr, wdata, wr_stb} <= {a, d, 1'b1};
    @(posedge clock) wr_stb <= 1'b0;
  endtask : wr
  task rd(logic [3:0] a, logic [15:0] e, string n);
    @(posedge clock) {addr, rd_stb} <= {a, 1'b1};
    @(posedge clock) rd_stb <= 1'b0;
    #1 ck(n, e, rdata);
  endtask : rd
  task final_report;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // Watchdog
  initial begin
    #50000;
    errors++;
    final_report();
  end
  // Main sequence
  initial begin
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    rd(4'h2, 16'hffff, "greg_b_reset");
    rd(4'h0, 16'h0000, "ctrl_reset");
    rd(4'h7, 16'h0000, "unmapped");
    for (logic [3:0] f = 4'h1; f < 4'h8; f++) begin
      r = nx(r);
      wr(4'h5, {15'h0, f != 4'h3});
      wr(4'h0, {8'h0, f, 4'h0});
      wr(4'h2, r);
      @(posedge clock) cnt <= r;
      @(posedge clock) cnt <= 16'h0;
      repeat (3) @(posedge clock);
      ck("b_out", {15'h0, mexp(f)}, {15'h0, b_out});
      ck("b_oe", {15'h0, f[1:0] != 2'h0}, {15'h0, b_oe});
      ck("irq", {15'h0, f[1:0] != 2'h0 && f != 4'h3}, {15'h0, irq});
      rd(4'h4, {15'h0, f[1:0] != 2'h0}, "status_b");
      wr(4'h4, 16'h0003);
    end
    for (int i = 0; i < 7; i++) begin
      r = nx(r);
      w = ~r;
      d_ext <= i[0];
      wr(4'h6, {15'h0, i == 6});
      wr(4'h1, {8'h0, fs[i], 4'h0});
      wr(4'h3, w);
      cnt <= r;
      wr(4'h4, 16'h0003);
      d_ext <= !i[0];
      repeat (4) @(posedge clock);
      rd(4'h3, cexp(fs[i], i[0], i == 6) ? r : w, "greg_d");
      rd(4'h4, {14'h0, cexp(fs[i], i[0], i == 6), 1'b0}, "status_d");
    end
    wr(4'h0, 16'h00c0);
    for (int p = 0; p < 2; p++) begin
      r = nx(r);
      w = ~r;
      psc <= p[2:0];
      wr(4'h2, w);
      cnt <= r;
      wr(4'h4, 16'h0003);
      tick <= 1'b1;
      @(posedge clock) tick <= 1'b0;
      repeat (3) @(posedge clock);
      rd(4'h2, p == 1 ? r : w, "greg_b_cascade");
    end
    // D compare drives high, B captures on a falling pin edge
    wr(4'h6, 16'h0000);
    wr(4'h1, 16'h0020);
    wr(4'h0, 16'h0090);
    r = nx(r);
    wr(4'h3, r);
    wr(4'h2, ~r);
    b_ext <= 1'b1;
    wr(4'h4, 16'h0003);
    {cnt, b_ext} <= {r, 1'b0};
    repeat (3) @(posedge clock);
    ck("d_out", 16'h0001, {15'h0, d_out});
    ck("d_oe", 16'h0001, {15'h0, d_oe});
    ck("irq_both", 16'h0001, {15'h0, irq});
    rd(4'h2, r, "greg_b_fall");
    rd(4'h4, 16'h0003, "status_both");
    final_report();
  end
endmodule : tb_top
